// *** sram_host.sv ***
// Memory controller end: turns user requests into SRAM pin cycles
`default_nettype none
`include "sram_defs.svh"
module sram_host #(
   parameter int AW = `SRAM_ADDR_W,
   parameter int NL = `SRAM_LANES
) (
   input  wire logic            ref_clk,
   input  wire logic            arst_n,
   input  wire logic            req_valid,
   output var  logic            req_ready,
   input  wire logic            req_write,
   input  wire logic            req_burst,
   input  wire logic [AW-1:0]   req_addr,
   input  wire logic [NL-1:0]   req_lanes,
   input  wire logic [8*NL-1:0] req_wdata,
   input  wire logic            flow_mode,
   input  wire logic            interleave,
   input  wire logic            sleep,
   output var  logic            rsp_valid,
   input  wire logic            rsp_ready,
   output var  logic [8*NL-1:0] rsp_data,
   sram_if.host                 bus
);
   localparam int DW = 8 * NL;

   // =====================================================
   // Issue stage; stalls via req_ready once buffered plus in-flight reads reach two
   // same beat order as the device counter
   function automatic logic [1:0] beat_low(input logic [1:0] start, input logic [1:0] cnt, input logic il);
      beat_low = il ? (start ^ cnt) : 2'(start + cnt);
   endfunction

   logic            stall;
   logic [3:0]      rd_pipe_q;
   logic            brk_q;
   logic [AW-1:0]   hb_base_q;
   logic [1:0]      hb_cnt_q;
   logic [AW-1:0]   resume_addr;
   logic [DW-1:0]   wd_q [3];
   logic [2:0]      wv_q;
   logic [1:0]      rb_cnt_q;
   logic [DW-1:0]   rb_data_q [2];
   logic            rb_wp_q;
   logic            rb_rp_q;
   logic            rb_push;
   logic            rb_pop;
   logic [2:0]      inflight;

   // Counts every read not yet in the buffer, including one landing this edge
   assign inflight  = 3'(rd_pipe_q[0]) + 3'(rd_pipe_q[1]) + 3'(rd_pipe_q[2]) + 3'(rd_pipe_q[3] && !flow_mode);
   assign stall     = (3'(rb_cnt_q) + inflight) > 3'h1;
   assign req_ready = !stall && !sleep;
   // Idle cycle deselects, so a burst resumed after it is replayed as loads
   assign resume_addr = {hb_base_q[AW-1:2], beat_low(hb_base_q[1:0], 2'(hb_cnt_q + 2'h1), interleave)};

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         brk_q     <= 1'b0;
         hb_base_q <= '0;
         hb_cnt_q  <= 2'h0;
      end else if (req_valid && req_ready) begin
         if (req_burst) begin
            hb_cnt_q <= hb_cnt_q + 2'h1;
         end else begin
            brk_q     <= 1'b0;
            hb_base_q <= req_addr;
            hb_cnt_q  <= 2'h0;
         end
      end else begin
         brk_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.clk_gate_n         <= 1'b0;
         bus.select_a_n         <= 1'b1;
         bus.select_b           <= 1'b0;
         bus.select_c_n         <= 1'b1;
         bus.write_n            <= 1'b1;
         bus.byte_lane_we_n     <= '1;
         bus.advance_load       <= 1'b0;
         bus.out_en_n           <= 1'b0;
         bus.sleep_req          <= 1'b0;
         bus.flow_through_sel_n <= 1'b1;
         bus.linear_order_sel_n <= 1'b0;
         bus.addr               <= '0;
      end else begin
         bus.sleep_req          <= sleep;
         bus.flow_through_sel_n <= !flow_mode;
         bus.linear_order_sel_n <= interleave;
         bus.clk_gate_n         <= 1'b0;
         if (req_valid && req_ready) begin
            // load unless an unbroken burst continues
            bus.advance_load   <= req_burst && !brk_q;
            bus.select_a_n     <= 1'b0;
            bus.select_b       <= 1'b1;
            bus.select_c_n     <= 1'b0;
            bus.write_n        <= !req_write;
            bus.byte_lane_we_n <= req_write ? ~req_lanes : '1;
            bus.addr           <= (req_burst && brk_q) ? resume_addr : req_addr;
         end else begin
            bus.advance_load   <= 1'b0;
            bus.select_a_n     <= 1'b1;
            bus.write_n        <= 1'b1;
            bus.byte_lane_we_n <= '1;
         end
      end
   end

   // =====================================================
   // Data lag tracking: write data and read capture
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pipe_q <= '0;
         wv_q      <= '0;
         for (int i = 0; i < 3; i++) begin
            wd_q[i] <= '0;
         end
      end else begin
         rd_pipe_q <= {rd_pipe_q[2:0], req_valid && req_ready && !req_write};
         wv_q      <= {wv_q[1:0], req_valid && req_ready && req_write};
         wd_q[0]   <= req_wdata;
         wd_q[1]   <= wd_q[0];
         wd_q[2]   <= wd_q[1];
      end
   end

   // Pins lag user request by one edge, so data slots shift by one
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.dq_host      <= '0;
         bus.dq_host_oe_n <= 1'b1;
      end else if (flow_mode) begin
         bus.dq_host      <= wd_q[0];
         bus.dq_host_oe_n <= !wv_q[0];
      end else begin
         bus.dq_host      <= wd_q[1];
         bus.dq_host_oe_n <= !wv_q[1];
      end
   end

   // =====================================================
   // Two-entry response buffer
   assign rb_push = (flow_mode ? rd_pipe_q[2] : rd_pipe_q[3]) && !bus.dq_dev_oe_n;
   assign rb_pop  = rsp_valid && rsp_ready;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rb_cnt_q     <= 2'h0;
         rb_wp_q      <= 1'b0;
         rb_rp_q      <= 1'b0;
         rb_data_q[0] <= '0;
         rb_data_q[1] <= '0;
      end else begin
         if (rb_push && rb_cnt_q != 2'h2) begin
            rb_data_q[rb_wp_q] <= bus.dq_dev;
            rb_wp_q            <= !rb_wp_q;
         end
         if (rb_pop) begin
            rb_rp_q <= !rb_rp_q;
         end
         rb_cnt_q <= rb_cnt_q + 2'(rb_push && rb_cnt_q != 2'h2) - 2'(rb_pop);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end else begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
         if (rb_cnt_q != 2'h0 && !(rsp_valid && rsp_ready && rb_cnt_q == 2'h1)) begin
            rsp_valid <= 1'b1;
            rsp_data  <= rb_data_q[rb_rp_q ^ rb_pop];
         end
      end
   end
endmodule // sram_host
`default_nettype wire

// *** sram_defs.svh ***
// Timing and width constants for the synchronous SRAM link
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH
`define SRAM_ADDR_W      16
`define SRAM_LANES       4
`define SRAM_BURST_LEN   4
`define SRAM_PIPE_LAG    2
`define SRAM_FLOW_LAG    1
`define SRAM_SLEEP_LAG   2
`define SRAM_WAKE_LAG    2
`endif

// *** sram_pkg.sv ***
// Types used by the SRAM device end; the controller end uses none
`default_nettype none
package sram_pkg;
   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_READ,
      CMD_WRITE
   } cmd_t;
endpackage
`default_nettype wire

// *** sram_if.sv ***
// Pin-level link between memory controller and synchronous SRAM
`default_nettype none
`include "sram_defs.svh"
interface sram_if #(parameter int AW = `SRAM_ADDR_W, parameter int NL = `SRAM_LANES);
   logic            clk_gate_n;
   logic            select_a_n;
   logic            select_b;
   logic            select_c_n;
   logic            write_n;
   logic [NL-1:0]   byte_lane_we_n;
   logic            advance_load;
   logic            out_en_n;
   logic            sleep_req;
   logic            flow_through_sel_n;
   logic            linear_order_sel_n;
   logic [AW-1:0]   addr;
   logic [8*NL-1:0] dq_host;
   logic            dq_host_oe_n;
   logic [8*NL-1:0] dq_dev;
   logic            dq_dev_oe_n;
   modport host (
      output clk_gate_n, select_a_n, select_b, select_c_n, write_n, byte_lane_we_n, advance_load,
             out_en_n, sleep_req, flow_through_sel_n, linear_order_sel_n, addr, dq_host, dq_host_oe_n,
      input  dq_dev, dq_dev_oe_n
   );
   modport dev (
      input  clk_gate_n, select_a_n, select_b, select_c_n, write_n, byte_lane_we_n, advance_load,
             out_en_n, sleep_req, flow_through_sel_n, linear_order_sel_n, addr, dq_host, dq_host_oe_n,
      output dq_dev, dq_dev_oe_n
   );
endinterface
`default_nettype wire

// *** sram_device.sv ***
// Synchronous SRAM device end: command decode, burst counter, late write, read pipe
// How it works
// - Clock gate high freezes all state but sleep entry and wake.
// - Sync inputs sampled on rising edges only.
// - Host starts each access with load.
// - Selected only when all three selects active.
// - Low byte enables write their lanes.
// - Write with no lanes is abort.
// - Read loads external address on load edge.
// - Pipelined read data after third edge.
// - Pipelined write data two edges later.
// - Flow-through read one cycle sooner.
// - Flow-through write data one edge later.
// - Load with inactive select deselects.
// - Advance continues burst, ignores selects.
// - Advance after deselect stays deselected.
// - Output enable high gives dummy read.
// - Drivers off in writes; enable overrides.
// - Gated clock holds read data driven.
// - Outputs high impedance from reset.
// - Two-bit counter advances every continue.
// - Wraps after four; order select linear/interleaved.
// - Flow select low means flow-through.
// - Sleep after two cycles, wake two later.
`default_nettype none
`include "sram_defs.svh"
module sram_device #(
   parameter int AW    = `SRAM_ADDR_W,
   parameter int NL    = `SRAM_LANES,
   parameter int DEPTH = 256
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   sram_if.dev       bus
);
   localparam int DW = 8 * NL;
   localparam int IW = $clog2(DEPTH);

   initial begin
      if (DEPTH < `SRAM_BURST_LEN || DEPTH > (1 << AW) || IW < 2) begin
         $error("sram_device: unsupported DEPTH");
      end
   end

   // =====================================================
   // Burst address generation
   // order function
   function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt,
                                            input logic lin_n);
      burst_low = lin_n ? (start ^ cnt) : 2'(start + cnt);
   endfunction

   logic [DW-1:0]      mem [DEPTH];
   logic               run;
   logic [1:0]         sleep_cnt_q;
   logic               asleep_q;
   sram_pkg::cmd_t     burst_q;
   logic [AW-1:0]      base_q;
   logic [1:0]         cnt_q;
   logic               selected;
   logic               load;
   sram_pkg::cmd_t     cmd;
   logic [AW-1:0]      acc_addr;
   logic [NL-1:0]      acc_lanes;
   // Write pipe: stage 0 = just registered, stage 1 = one edge later
   logic               wr_v_q [2];
   logic [AW-1:0]      wr_a_q [2];
   logic [NL-1:0]      wr_l_q [2];
   logic               rd_v_q;
   logic [AW-1:0]      rd_a_q;
   logic               rd_oe_q;
   logic [DW-1:0]      q_q;
   logic               q_v_q;
   logic               wr_due;
   logic [AW-1:0]      wr_due_a;
   logic [NL-1:0]      wr_due_l;

   assign run      = !bus.clk_gate_n && !asleep_q && !bus.sleep_req;
   assign selected = !bus.select_a_n && bus.select_b && !bus.select_c_n;
   assign load     = !bus.advance_load;

   always_comb begin
      cmd       = sram_pkg::CMD_NONE;
      acc_addr  = bus.addr;
      acc_lanes = ~bus.byte_lane_we_n;
      if (load) begin
         if (selected) begin
            cmd = bus.write_n ? sram_pkg::CMD_READ : sram_pkg::CMD_WRITE;
         end
      end else begin
         cmd      = burst_q;
         acc_addr = {base_q[AW-1:2], burst_low(base_q[1:0], 2'(cnt_q + 2'h1), bus.linear_order_sel_n)};
      end
   end

   // =====================================================
   // Sleep entry and wake
   // two-cycle lag
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_cnt_q <= 2'h0;
         asleep_q    <= 1'b0;
      end else if (bus.sleep_req != asleep_q) begin
         if (sleep_cnt_q == 2'(`SRAM_SLEEP_LAG - 1)) begin
            asleep_q    <= bus.sleep_req;
            sleep_cnt_q <= 2'h0;
         end else begin
            sleep_cnt_q <= sleep_cnt_q + 2'h1;
         end
      end else begin
         sleep_cnt_q <= 2'h0;
      end
   end

   // =====================================================
   // Burst state
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         burst_q <= sram_pkg::CMD_NONE;
         base_q  <= '0;
         cnt_q   <= 2'h0;
      end else if (asleep_q) begin
         burst_q <= sram_pkg::CMD_NONE;
      end else if (run) begin
         if (load) begin
            burst_q <= cmd;
            base_q  <= bus.addr;
            cnt_q   <= 2'h0;
         end else begin
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end

   // =====================================================
   // Write pipeline
   // pipelined two-edge lag
   assign wr_due   = bus.flow_through_sel_n ? wr_v_q[1] : wr_v_q[0];
   assign wr_due_a = bus.flow_through_sel_n ? wr_a_q[1] : wr_a_q[0];
   assign wr_due_l = bus.flow_through_sel_n ? wr_l_q[1] : wr_l_q[0];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 2; i++) begin
            wr_v_q[i] <= 1'b0;
            wr_a_q[i] <= '0;
            wr_l_q[i] <= '0;
         end
      end else if (run) begin
         wr_v_q[0] <= (cmd == sram_pkg::CMD_WRITE) && (acc_lanes != '0);
         wr_a_q[0] <= acc_addr;
         wr_l_q[0] <= acc_lanes;
         wr_v_q[1] <= wr_v_q[0];
         wr_a_q[1] <= wr_a_q[0];
         wr_l_q[1] <= wr_l_q[0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (run && wr_due) begin
         for (int b = 0; b < NL; b++) begin
            if (wr_due_l[b]) begin
               mem[IW'(wr_due_a)][8*b +: 8] <= bus.dq_host[8*b +: 8];
            end
         end
      end
   end

   // =====================================================
   // Read path
   // output register stage
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_v_q  <= 1'b0;
         rd_a_q  <= '0;
         rd_oe_q <= 1'b0;
         q_q     <= '0;
         q_v_q   <= 1'b0;
      end else if (asleep_q) begin
         rd_v_q <= 1'b0;
         q_v_q  <= 1'b0;
      end else if (run) begin
         rd_v_q  <= (cmd == sram_pkg::CMD_READ);
         rd_a_q  <= acc_addr;
         rd_oe_q <= !bus.out_en_n;
         q_v_q   <= bus.flow_through_sel_n ? (rd_v_q && rd_oe_q)
                                           : ((cmd == sram_pkg::CMD_READ) && !bus.out_en_n);
         q_q     <= bus.flow_through_sel_n ? mem[IW'(rd_a_q)] : mem[IW'(acc_addr)];
      end
   end

   // =====================================================
   // Output drivers, registered
   // off in writes, enable override
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus.dq_dev      <= '0;
         bus.dq_dev_oe_n <= 1'b1;
      end else begin
         bus.dq_dev      <= q_q;
         bus.dq_dev_oe_n <= !(q_v_q && !asleep_q && !bus.sleep_req);
      end
   end
endmodule // sram_device
`default_nettype wire

// *** sram_link_assertions.sv ***
// Concurrent checks on the controller-to-SRAM pin link
`default_nettype none
module sram_link_assertions #(
   parameter int AW = 16,
   parameter int NL = 4
) (
   input wire logic            ref_clk,
   input wire logic            arst_n,
   input wire logic            clk_gate_n,
   input wire logic            select_a_n,
   input wire logic            select_b,
   input wire logic            select_c_n,
   input wire logic            write_n,
   input wire logic [NL-1:0]   byte_lane_we_n,
   input wire logic            advance_load,
   input wire logic            out_en_n,
   input wire logic            sleep_req,
   input wire logic            flow_through_sel_n,
   input wire logic            linear_order_sel_n,
   input wire logic [AW-1:0]   addr,
   input wire logic [8*NL-1:0] dq_host,
   input wire logic            dq_host_oe_n,
   input wire logic [8*NL-1:0] dq_dev,
   input wire logic            dq_dev_oe_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================
   // Command decode as seen on the pins
   wire logic go  = !clk_gate_n && !sleep_req;
   wire logic sel = !select_a_n && select_b && !select_c_n;
   wire logic rd  = go && sel && write_n && !advance_load;
   // Abort is excluded: no data is owed for it
   wire logic wr  = go && sel && !write_n && !advance_load && !(&byte_lane_we_n);
   // ==========================================
   // Link properties
   a_reset_quiet: assert property ($rose(arst_n) |-> dq_dev_oe_n && dq_host_oe_n)
      else $error("data driven at reset release");
   a_no_contention: assert property (!dq_dev_oe_n |-> dq_host_oe_n)
      else $error("both ends drive the data bus");
   a_oe_override: assert property (out_en_n ##1 out_en_n |-> dq_dev_oe_n)
      else $error("data driven with output enable high");
   a_read_flow: assert property ((rd && !out_en_n && !flow_through_sel_n) ##1 go |-> ##1 !dq_dev_oe_n)
      else $error("flow-through read data not driven");
   a_read_pipe: assert property ((rd && !out_en_n && flow_through_sel_n) ##1 go ##1 go |-> ##1 !dq_dev_oe_n)
      else $error("pipelined read data not driven");
   a_deselect_quiet: assert property ((go && !sel && !advance_load) ##1 (go && !sel) ##1 go |-> ##1 dq_dev_oe_n)
      else $error("data driven after deselect");
   a_write_pipe: assert property ((wr && flow_through_sel_n) ##1 go |-> ##1 !dq_host_oe_n && dq_dev_oe_n)
      else $error("pipelined write data missing at third edge");
   a_write_flow: assert property (wr && !flow_through_sel_n |-> ##1 !dq_host_oe_n)
      else $error("flow-through write data missing at second edge");
   a_burst_read: assert property (rd ##1 (go && advance_load) ##1 go ##1 !out_en_n |-> !dq_dev_oe_n)
      else $error("burst read beat not driven");
   a_sleep_quiet: assert property (sleep_req [*4] |-> dq_dev_oe_n)
      else $error("data driven while asleep");
endmodule // sram_link_assertions
`default_nettype wire

// *** tb_sync_sram_rw_control.sv ***
// Self-checking bench: controller and SRAM ends joined by the pin interface
`default_nettype none
module tb_sync_sram_rw_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'h0;
   logic        arst_n = 1'h0;
   logic        req_valid = 1'h0;
   logic        req_ready;
   logic        req_write = 1'h0;
   logic        req_burst = 1'h0;
   logic [15:0] req_addr = 16'h0;
   logic [3:0]  req_lanes = 4'h0;
   logic [31:0] req_wdata = 32'h0;
   logic        flow_mode = 1'h0;
   logic        interleave = 1'h0;
   logic        sleep = 1'h0;
   logic        rsp_valid;
   logic        rsp_ready = 1'h1;
   logic [31:0] rsp_data;
   logic [31:0] mem [0:255];
   logic [31:0] got [$];
   logic [31:0] exp [$];
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cycles = 0;
   sram_if sif ();
   always #20 ref_clk = ~ref_clk;
   sram_host sram_host_inst (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_burst(req_burst), .req_addr(req_addr), .req_lanes(req_lanes),
      .req_wdata(req_wdata), .flow_mode(flow_mode), .interleave(interleave), .sleep(sleep),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .bus(sif.host));
   sram_device sram_device_inst (.ref_clk(ref_clk), .arst_n(arst_n), .bus(sif.dev));
   sram_link_assertions sram_link_assertions_inst (.ref_clk(ref_clk), .arst_n(arst_n),
      .clk_gate_n(sif.clk_gate_n), .select_a_n(sif.select_a_n), .select_b(sif.select_b),
      .select_c_n(sif.select_c_n), .write_n(sif.write_n), .byte_lane_we_n(sif.byte_lane_we_n),
      .advance_load(sif.advance_load), .out_en_n(sif.out_en_n), .sleep_req(sif.sleep_req),
      .flow_through_sel_n(sif.flow_through_sel_n), .linear_order_sel_n(sif.linear_order_sel_n),
      .addr(sif.addr), .dq_host(sif.dq_host), .dq_host_oe_n(sif.dq_host_oe_n), .dq_dev(sif.dq_dev),
      .dq_dev_oe_n(sif.dq_dev_oe_n));
   // ==========================================
   // Response capture and hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (rsp_valid === 1'h1 && rsp_ready === 1'h1)
         got.push_back(rsp_data);
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // ==========================================
   // Shared tasks
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   // Leaves valid high so back-to-back calls never toggle it twice in one step
   task automatic put(input logic w, input logic b, input logic [7:0] a, input logic [3:0] ln, input logic [31:0] d);
      int n;
      n = 0;
      req_write = w;
      req_burst = b;
      req_addr = {8'h00, a};
      req_lanes = ln;
      req_wdata = d;
      req_valid = 1'h1;
      while (req_ready !== 1'h1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      for (int k = 0; k < 4; k++)
         if (w && ln[k])
            mem[a][8*k +: 8] = d[8*k +: 8];
   endtask
   task automatic idle(input int k);
      req_valid = 1'h0;
      repeat (k) @(negedge ref_clk);
   endtask
   task automatic settle();
      int n;
      n = 0;
      idle(2);
      while (got.size() < exp.size() && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      chk(32'(got.size()), 32'(exp.size()));
      while (exp.size() > 0 && got.size() > 0)
         chk(got.pop_front(), exp.pop_front());
      got.delete();
      exp.delete();
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      chk({31'h0, sif.dq_dev_oe_n}, 32'h1);
      chk({31'h0, rsp_valid}, 32'h0);
   endtask
   task automatic t_lanes(input logic m);
      logic [3:0] tab [6];
      tab = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
      flow_mode = m;
      idle(4);
      for (int i = 0; i < 6; i++)
         put(1'h1, 1'h0, 8'h10 + 8'(i), 4'hF, 32'hA5C3_0000 | 32'(i));
      for (int i = 0; i < 6; i++)
         put(1'h1, 1'h0, 8'h10 + 8'(i), tab[i], 32'h1234_5678 ^ {24'h0, 8'(m)});
      for (int i = 0; i < 6; i++) begin
         put(1'h0, 1'h0, 8'h10 + 8'(i), 4'h0, 32'h0);
         exp.push_back(mem[8'h10 + 8'(i)]);
      end
      settle();
   endtask
   // Burst from start 1 with five beats; fifth wraps back, reader stalls meanwhile
   task automatic t_burst(input logic il);
      logic [1:0] lo;
      flow_mode = il;
      interleave = il;
      idle(4);
      for (int i = 0; i < 4; i++)
         put(1'h1, 1'h0, 8'h20 + 8'(i), 4'hF, 32'hC0DE_0000 | 32'(i * 17));
      rsp_ready = 1'h0;
      fork
         begin
            repeat (12) @(negedge ref_clk);
            rsp_ready = 1'h1;
         end
      join_none
      for (int k = 0; k < 5; k++) begin
         put(1'h0, k != 0, 8'h21, 4'h0, 32'h0);
         lo = il ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
         exp.push_back(mem[{6'h08, lo}]);
      end
      settle();
   endtask
   task automatic t_sleep();
      idle(2);
      sleep = 1'h1;
      repeat (8) @(negedge ref_clk);
      chk({31'h0, sif.dq_dev_oe_n}, 32'h1);
      sleep = 1'h0;
      idle(6);
      put(1'h0, 1'h0, 8'h12, 4'h0, 32'h0);
      exp.push_back(mem[8'h12]);
      settle();
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      t_reset();
      arst_n = 1'h1;
      @(negedge ref_clk);
      t_lanes(1'h0);
      t_lanes(1'h1);
      t_burst(1'h0);
      t_burst(1'h1);
      t_sleep();
      report_and_stop();
   end
endmodule // tb_sync_sram_rw_control
`default_nettype wire
